// File: core/iat_regs.sv
// Input alarm threshold registers, window comparator and interrupt on an AHB-Lite slave
//
// Our own choice: the AHB-Lite interface to the registers.
`timescale 1ns/1ps
`include "iat_defines.svh"

// Operation
// - Hysteresis uses top two hysteresis bits
// - Upper threshold low half, resets ones
// - Lower threshold low half, resets zero
// - Upper register bits 23..16 read zero
// - Lower register top half reads zero
// - Upper register byte addressed 24h..27h
// - Lower register byte addressed 28h..2Bh
// - Read-only tripped flags high and low
// - Overall alarm is OR of trips
module iat_regs (
    input  wire logic        hclk,
    input  wire logic        hresetn,
    input  wire logic        hsel,
    input  wire logic [31:0] haddr,
    input  wire logic [1:0]  htrans,
    input  wire logic        hwrite,
    input  wire logic [2:0]  hsize,
    input  wire logic [31:0] hwdata,
    input  wire logic        hready,
    output logic      [31:0] hrdata,
    output logic             hreadyout,
    output logic             hresp,
    input  wire logic        conv_valid,
    input  wire logic [11:0] conv_result,
    output logic             trip_high,
    output logic             trip_low,
    output logic             overall_alarm_bit,
    output logic             irq
);

    iat_pkg::iat_cfg_t   cfg, next_cfg;
    iat_pkg::iat_trip_t  trip, next_trip;
    iat_pkg::iat_phase_t phase, next_phase;
    logic [7:0]  addr_q, next_addr_q;
    logic [3:0]  be_q, next_be_q;
    logic [1:0]  irq_stat, next_irq_stat;
    logic [1:0]  irq_mask, next_irq_mask;
    logic [11:0] last_sample, next_last_sample;
    logic [31:0] next_hrdata;
    logic [31:0] high_word, low_word, wmask;
    logic [31:0] high_merge;
    logic [7:0]  word_addr;
    logic [12:0] hyst_amt;
    logic [12:0] high_cmp, low_cmp;
    logic        take;

    // Single-cycle answers: the slave never stretches a transfer
    assign hreadyout = 1'b1;
    assign hresp     = 1'b0;

    assign take = hsel && hready && htrans == `IAT_HTRANS_NONSEQ;

    // Reserved bytes are built as zero rather than stored
    assign high_word = {cfg.hyst, 8'h00, cfg.high_th};
    assign low_word  = {16'h0000, cfg.low_th};

    // Byte enables let each byte address hit its own lane
    always_comb begin
        next_be_q = 4'h0;
        case (hsize)
            3'h0: next_be_q = 4'h1 << haddr[1:0];
            3'h1: next_be_q = haddr[1] ? 4'hc : 4'h3;
            default: next_be_q = 4'hf;
        endcase
    end

    assign wmask = {{8{be_q[3]}}, {8{be_q[2]}}, {8{be_q[1]}}, {8{be_q[0]}}};

    // Merged upper word; only the top byte is kept from it
    assign high_merge = (high_word & ~wmask) | (hwdata & wmask);
    assign word_addr  = {haddr[`IAT_ADDR_MSB:`IAT_ADDR_LSB], 2'b00};

    always_comb begin
        next_phase  = iat_pkg::IAT_IDLE;
        next_addr_q = addr_q;
        if (take) begin
            next_phase  = hwrite ? iat_pkg::IAT_WRITE : iat_pkg::IAT_READ;
            next_addr_q = {haddr[`IAT_ADDR_MSB:`IAT_ADDR_LSB], 2'b00};
        end
    end

    // Register writes; low nibbles are kept as written, host keeps them zero
    always_comb begin
        next_cfg      = cfg;
        next_irq_mask = irq_mask;
        if (phase == iat_pkg::IAT_WRITE) begin
            case (addr_q)
                `IAT_OFS_HIGH: begin
                    next_cfg.hyst    = high_merge[`IAT_HYST_MSB:`IAT_HYST_LSB];
                    next_cfg.high_th = (cfg.high_th & ~wmask[15:0]) | (hwdata[15:0] & wmask[15:0]);
                end
                `IAT_OFS_LOW: begin
                    next_cfg.low_th = (cfg.low_th & ~wmask[15:0]) | (hwdata[15:0] & wmask[15:0]);
                end
                `IAT_OFS_IRQ_MASK: next_irq_mask = hwdata[1:0] & wmask[1:0] | irq_mask & ~wmask[1:0];
                default: ;
            endcase
        end
    end

    // Read data is registered: data follows one cycle after the address phase
    always_comb begin
        next_hrdata = 32'h0000_0000;
        if (take && !hwrite) begin
            case ({haddr[`IAT_ADDR_MSB:`IAT_ADDR_LSB], 2'b00})
                `IAT_OFS_FLAGS:    next_hrdata = {26'h0, trip.trip_low, trip.trip_high, 3'h0, overall_alarm_bit};
                `IAT_OFS_HIGH:     next_hrdata = high_word;
                `IAT_OFS_LOW:      next_hrdata = low_word;
                `IAT_OFS_IRQ_STAT: next_hrdata = {30'h0, irq_stat};
                `IAT_OFS_IRQ_MASK: next_hrdata = {30'h0, irq_mask};
                `IAT_OFS_SAMPLE:   next_hrdata = {20'h0, last_sample};
                default:           next_hrdata = 32'h0000_0000;
            endcase
        end
    end

    // Hysteresis step in 12-bit codes: 0, 1, 2 or 3 codes below/above the limit
    assign hyst_amt = {11'h000, cfg.hyst[`IAT_HYST_VAL_MSB:`IAT_HYST_VAL_LSB]};
    assign high_cmp = {1'b0, cfg.high_th[`IAT_THR_MSB:`IAT_THR_LSB]};
    assign low_cmp  = {1'b0, cfg.low_th[`IAT_THR_MSB:`IAT_THR_LSB]};

    // Set above upper or below lower limit; release only once back inside by the hysteresis margin
    always_comb begin
        next_trip        = trip;
        next_last_sample = last_sample;
        if (conv_valid) begin
            next_last_sample = conv_result;
            if ({1'b0, conv_result} > high_cmp)
                next_trip.trip_high = 1'b1;
            else if ({1'b0, conv_result} + hyst_amt <= high_cmp)
                next_trip.trip_high = 1'b0;
            if ({1'b0, conv_result} < low_cmp)
                next_trip.trip_low = 1'b1;
            else if ({1'b0, conv_result} >= low_cmp + hyst_amt)
                next_trip.trip_low = 1'b0;
        end
    end

    // Sticky status: a new trip wins over a write-one clear in the same cycle
    always_comb begin
        next_irq_stat = irq_stat;
        if (phase == iat_pkg::IAT_WRITE && addr_q == `IAT_OFS_IRQ_STAT)
            next_irq_stat = irq_stat & ~(hwdata[1:0] & wmask[1:0]);
        if (next_trip.trip_high && !trip.trip_high)
            next_irq_stat[0] = 1'b1;
        if (next_trip.trip_low && !trip.trip_low)
            next_irq_stat[1] = 1'b1;
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            cfg         <= '{hyst: `IAT_HYST_RESET, high_th: `IAT_HIGH_RESET, low_th: `IAT_LOW_RESET};
            trip        <= '0;
            phase       <= iat_pkg::IAT_IDLE;
            addr_q      <= 8'h00;
            be_q        <= 4'h0;
            irq_stat    <= 2'h0;
            irq_mask    <= 2'h0;
            last_sample <= 12'h000;
            hrdata      <= 32'h0000_0000;
        end else begin
            cfg         <= next_cfg;
            trip        <= next_trip;
            phase       <= next_phase;
            addr_q      <= next_addr_q;
            if (take)
                be_q    <= next_be_q;
            irq_stat    <= next_irq_stat;
            irq_mask    <= next_irq_mask;
            last_sample <= next_last_sample;
            hrdata      <= next_hrdata;
        end
    end

    assign trip_high         = trip.trip_high;
    assign trip_low          = trip.trip_low;
    assign overall_alarm_bit = trip.trip_high | trip.trip_low;
    assign irq               = |(irq_stat & irq_mask);

    chk_high_reset_ones: assert property (@(posedge hclk) $rose(hresetn) |-> cfg.high_th == `IAT_HIGH_RESET)
        else $error("upper threshold not all ones after reset");
    chk_low_reset_zero: assert property (@(posedge hclk) $rose(hresetn) |-> cfg.low_th == `IAT_LOW_RESET)
        else $error("lower threshold not zero after reset");
    chk_high_reserved_zero: assert property (@(posedge hclk) disable iff (!hresetn)
        $past(take && !hwrite && haddr[7:0] == `IAT_OFS_HIGH) |-> hrdata[23:16] == 8'h00)
        else $error("upper register reserved byte not zero");
    chk_low_reserved_zero: assert property (@(posedge hclk) disable iff (!hresetn)
        $past(take && !hwrite && haddr[7:0] == `IAT_OFS_LOW) |-> hrdata[31:16] == 16'h0000)
        else $error("lower register upper half not zero");
    chk_byte_write_top: assert property (@(posedge hclk) disable iff (!hresetn)
        take && hwrite && haddr[7:0] == 8'h27 && hsize == 3'h0 ##1 1'b1 |=> cfg.hyst == $past(hwdata[31:24]))
        else $error("byte write to top of upper register lost");
    chk_byte_write_low: assert property (@(posedge hclk) disable iff (!hresetn)
        take && hwrite && haddr[7:0] == 8'h29 && hsize == 3'h0 ##1 1'b1 |=> cfg.low_th[15:8] == $past(hwdata[15:8]))
        else $error("byte write to lower register lost");
    chk_trip_high_set: assert property (@(posedge hclk) disable iff (!hresetn)
        conv_valid && conv_result > cfg.high_th[15:4] |=> trip_high)
        else $error("high alarm not raised above threshold");
    chk_trip_low_set: assert property (@(posedge hclk) disable iff (!hresetn)
        conv_valid && conv_result < cfg.low_th[15:4] |=> trip_low)
        else $error("low alarm not raised below threshold");
    chk_overall_or: assert property (@(posedge hclk) disable iff (!hresetn)
        $past(take && !hwrite && haddr[7:0] == `IAT_OFS_FLAGS) |-> hrdata[0] == (hrdata[4] | hrdata[5]))
        else $error("overall alarm bit differs from OR of trips");
    chk_trip_hold_hyst: assert property (@(posedge hclk) disable iff (!hresetn)
        trip_high && conv_valid && conv_result + cfg.hyst[7:6] > cfg.high_th[15:4] |=> trip_high)
        else $error("high alarm released inside hysteresis band");

    // Bus handshake and reset state
    chk_ready_always: assert property (@(posedge hclk) disable iff (!hresetn) hreadyout == 1'b1)
        else $error("slave inserted a wait state");
    chk_resp_okay: assert property (@(posedge hclk) disable iff (!hresetn) hresp == 1'b0)
        else $error("slave answered with an error response");
    chk_reset_clears: assert property (@(posedge hclk) !hresetn |->
        hrdata == 32'h0000_0000 && !trip_high && !trip_low && !irq && hreadyout)
        else $error("outputs not quiet during reset");
    chk_addr_capture: assert property (@(posedge hclk) disable iff (!hresetn)
        take |=> addr_q == $past(word_addr))
        else $error("word address not captured");
    chk_phase_on_take: assert property (@(posedge hclk) disable iff (!hresetn)
        take |=> phase == ($past(hwrite) ? iat_pkg::IAT_WRITE : iat_pkg::IAT_READ))
        else $error("data phase kind wrong");
    chk_phase_idle: assert property (@(posedge hclk) disable iff (!hresetn)
        !take |=> phase == iat_pkg::IAT_IDLE)
        else $error("data phase without address phase");
    chk_byte_lane_one: assert property (@(posedge hclk) disable iff (!hresetn)
        take && hsize == 3'h0 |=> $onehot(be_q))
        else $error("byte transfer enabled more than one lane");
    chk_half_lane_pair: assert property (@(posedge hclk) disable iff (!hresetn)
        take && hsize == 3'h1 |=> be_q == 4'h3 || be_q == 4'hc)
        else $error("halfword transfer lanes wrong");
    chk_word_lanes_all: assert property (@(posedge hclk) disable iff (!hresetn)
        take && hsize == 3'h2 |=> be_q == 4'hf)
        else $error("word transfer lanes wrong");
    chk_lanes_held: assert property (@(posedge hclk) disable iff (!hresetn)
        !take |=> $stable(be_q))
        else $error("lane enables changed without a transfer");
    // Read data
    chk_idle_rd_zero: assert property (@(posedge hclk) disable iff (!hresetn)
        $past(!(take && !hwrite)) |-> hrdata == 32'h0000_0000)
        else $error("read data not zero outside a read");
    chk_flags_reserved: assert property (@(posedge hclk) disable iff (!hresetn)
        $past(take && !hwrite && word_addr == `IAT_OFS_FLAGS) |-> hrdata[3:1] == 3'h0 && hrdata[31:6] == 26'h0)
        else $error("flag register reserved bits not zero");
    chk_flags_trips: assert property (@(posedge hclk) disable iff (!hresetn)
        $past(take && !hwrite && word_addr == `IAT_OFS_FLAGS) |-> hrdata[5:4] == $past({trip_low, trip_high}))
        else $error("tripped flags read wrong");
    chk_rd_high_word: assert property (@(posedge hclk) disable iff (!hresetn)
        $past(take && !hwrite && word_addr == `IAT_OFS_HIGH) |-> hrdata == $past({cfg.hyst, 8'h00, cfg.high_th}))
        else $error("upper register read wrong");
    chk_rd_low_word: assert property (@(posedge hclk) disable iff (!hresetn)
        $past(take && !hwrite && word_addr == `IAT_OFS_LOW) |-> hrdata[15:0] == $past(cfg.low_th))
        else $error("lower register read wrong");
    chk_rd_stat_word: assert property (@(posedge hclk) disable iff (!hresetn)
        $past(take && !hwrite && word_addr == `IAT_OFS_IRQ_STAT) |-> hrdata == {30'h0, $past(irq_stat)})
        else $error("status register read wrong");
    chk_rd_mask_word: assert property (@(posedge hclk) disable iff (!hresetn)
        $past(take && !hwrite && word_addr == `IAT_OFS_IRQ_MASK) |-> hrdata == {30'h0, $past(irq_mask)})
        else $error("mask register read wrong");
    chk_rd_sample_word: assert property (@(posedge hclk) disable iff (!hresetn)
        $past(take && !hwrite && word_addr == `IAT_OFS_SAMPLE) |-> hrdata == {20'h0, $past(last_sample)})
        else $error("last result read wrong");
    chk_rd_unmapped: assert property (@(posedge hclk) disable iff (!hresetn) $past(take && !hwrite &&
        !(word_addr inside {`IAT_OFS_FLAGS, `IAT_OFS_HIGH, `IAT_OFS_LOW, `IAT_OFS_IRQ_STAT, `IAT_OFS_IRQ_MASK,
        `IAT_OFS_SAMPLE})) |-> hrdata == 32'h0000_0000)
        else $error("unmapped address read not zero");
    // Register writes
    chk_high_word_write: assert property (@(posedge hclk) disable iff (!hresetn)
        phase == iat_pkg::IAT_WRITE && addr_q == `IAT_OFS_HIGH && be_q == 4'hf |=>
        cfg.high_th == $past(hwdata[15:0]) && cfg.hyst == $past(hwdata[31:24]))
        else $error("word write to upper register lost");
    chk_low_word_write: assert property (@(posedge hclk) disable iff (!hresetn)
        phase == iat_pkg::IAT_WRITE && addr_q == `IAT_OFS_LOW && be_q == 4'hf |=> cfg.low_th == $past(hwdata[15:0]))
        else $error("word write to lower register lost");
    chk_low_keeps_high: assert property (@(posedge hclk) disable iff (!hresetn)
        phase == iat_pkg::IAT_WRITE && addr_q == `IAT_OFS_LOW |=> $stable(cfg.high_th) && $stable(cfg.hyst))
        else $error("lower register write disturbed upper register");
    chk_high_keeps_low: assert property (@(posedge hclk) disable iff (!hresetn)
        phase == iat_pkg::IAT_WRITE && addr_q == `IAT_OFS_HIGH |=> $stable(cfg.low_th))
        else $error("upper register write disturbed lower register");
    chk_cfg_only_write: assert property (@(posedge hclk) disable iff (!hresetn)
        phase != iat_pkg::IAT_WRITE |=> $stable(cfg))
        else $error("thresholds changed without a write");
    chk_mask_write: assert property (@(posedge hclk) disable iff (!hresetn)
        phase == iat_pkg::IAT_WRITE && addr_q == `IAT_OFS_IRQ_MASK && be_q[0] |=> irq_mask == $past(hwdata[1:0]))
        else $error("mask write lost");
    chk_mask_held: assert property (@(posedge hclk) disable iff (!hresetn)
        !(phase == iat_pkg::IAT_WRITE && addr_q == `IAT_OFS_IRQ_MASK) |=> $stable(irq_mask))
        else $error("mask changed without a write");
    // Comparator
    chk_sample_capture: assert property (@(posedge hclk) disable iff (!hresetn)
        conv_valid |=> last_sample == $past(conv_result))
        else $error("conversion result not captured");
    chk_sample_held: assert property (@(posedge hclk) disable iff (!hresetn)
        !conv_valid |=> $stable(last_sample))
        else $error("last result changed without a conversion");
    chk_trips_held: assert property (@(posedge hclk) disable iff (!hresetn)
        !conv_valid |=> $stable({trip_high, trip_low}))
        else $error("tripped flag changed without a conversion");
    chk_trip_high_clear: assert property (@(posedge hclk) disable iff (!hresetn)
        conv_valid && ({1'b0, conv_result} + hyst_amt) <= high_cmp |=> !trip_high)
        else $error("high alarm not released below the band");
    chk_trip_low_clear: assert property (@(posedge hclk) disable iff (!hresetn)
        conv_valid && {1'b0, conv_result} >= (low_cmp + hyst_amt) |=> !trip_low)
        else $error("low alarm not released above the band");
    chk_trip_low_hold: assert property (@(posedge hclk) disable iff (!hresetn)
        trip_low && conv_valid && {1'b0, conv_result} < (low_cmp + hyst_amt) |=> trip_low)
        else $error("low alarm released inside hysteresis band");
    chk_overall_is_or: assert property (@(posedge hclk) disable iff (!hresetn)
        overall_alarm_bit == (trip_high | trip_low))
        else $error("overall alarm differs from the trips");
    // Interrupt status and line
    chk_stat_high_set: assert property (@(posedge hclk) disable iff (!hresetn)
        $rose(trip_high) |-> irq_stat[0])
        else $error("high trip did not set its status bit");
    chk_stat_low_set: assert property (@(posedge hclk) disable iff (!hresetn)
        $rose(trip_low) |-> irq_stat[1])
        else $error("low trip did not set its status bit");
    chk_stat_sticky: assert property (@(posedge hclk) disable iff (!hresetn)
        !(phase == iat_pkg::IAT_WRITE && addr_q == `IAT_OFS_IRQ_STAT) |=> (irq_stat & $past(irq_stat)) == $past(irq_stat))
        else $error("status bit cleared without a write");
    chk_stat_high_w1c: assert property (@(posedge hclk) disable iff (!hresetn) phase == iat_pkg::IAT_WRITE &&
        addr_q == `IAT_OFS_IRQ_STAT && hwdata[0] && be_q[0] && !conv_valid |=> !irq_stat[0])
        else $error("high status bit not cleared by a one");
    chk_stat_low_w1c: assert property (@(posedge hclk) disable iff (!hresetn) phase == iat_pkg::IAT_WRITE &&
        addr_q == `IAT_OFS_IRQ_STAT && hwdata[1] && be_q[0] && !conv_valid |=> !irq_stat[1])
        else $error("low status bit not cleared by a one");
    chk_set_wins_high: assert property (@(posedge hclk) disable iff (!hresetn) phase == iat_pkg::IAT_WRITE &&
        addr_q == `IAT_OFS_IRQ_STAT && hwdata[0] && be_q[0] && next_trip.trip_high && !trip.trip_high |=> irq_stat[0])
        else $error("clear won over a new high trip");
    chk_irq_needs_mask: assert property (@(posedge hclk) disable iff (!hresetn)
        irq |-> irq_mask != 2'h0)
        else $error("interrupt raised with every source masked");
    chk_irq_high_path: assert property (@(posedge hclk) disable iff (!hresetn)
        $rose(trip_high) && irq_mask[0] |-> irq)
        else $error("unmasked high trip did not raise the interrupt");

    cov_high_trip: cover property (@(posedge hclk) disable iff (!hresetn) $rose(trip_high));
    cov_low_release: cover property (@(posedge hclk) disable iff (!hresetn) $fell(trip_low));
    cov_low_trip: cover property (@(posedge hclk) disable iff (!hresetn) $rose(trip_low));
    cov_irq: cover property (@(posedge hclk) disable iff (!hresetn) $rose(irq));
    cov_release: cover property (@(posedge hclk) disable iff (!hresetn) $fell(trip_high));

endmodule

// File: core/iat_defines.svh
// Register offsets, field positions and reset values of the input alarm threshold bank
`ifndef IAT_DEFINES_SVH
`define IAT_DEFINES_SVH

`define IAT_OFS_FLAGS      8'h20
`define IAT_OFS_HIGH       8'h24
`define IAT_OFS_LOW        8'h28
`define IAT_OFS_IRQ_STAT   8'h30
`define IAT_OFS_IRQ_MASK   8'h34
`define IAT_OFS_SAMPLE     8'h38

`define IAT_HIGH_RESET     16'hffff
`define IAT_LOW_RESET      16'h0000
`define IAT_HYST_RESET     8'h00
`define IAT_THR_MSB        15
`define IAT_THR_LSB        4
`define IAT_HYST_MSB       31
`define IAT_HYST_LSB       24
`define IAT_HYST_VAL_MSB   7
`define IAT_HYST_VAL_LSB   6
`define IAT_TRIP_HIGH_BIT  4
`define IAT_TRIP_LOW_BIT   5
`define IAT_OVERALL_BIT    0
`define IAT_HTRANS_NONSEQ  2'h2
`define IAT_ADDR_MSB       7
`define IAT_ADDR_LSB       2

`endif

// File: core/iat_pkg.sv
// Types shared by the input alarm threshold bank
package iat_pkg;

    typedef struct packed {
        logic [7:0]  hyst;
        logic [15:0] high_th;
        logic [15:0] low_th;
    } iat_cfg_t;

    typedef struct packed {
        logic trip_low;
        logic trip_high;
    } iat_trip_t;

    typedef enum logic [1:0] {
        IAT_IDLE,
        IAT_WRITE,
        IAT_READ
    } iat_phase_t;

endpackage

// File: verif/tb.sv
// Self-checking bench for the input alarm threshold registers
`timescale 1ns/1ps
`include "iat_defines.svh"

module tb;
    typedef struct packed {
        logic        wr;
        logic [7:0]  a;
        logic [2:0]  s;
        logic [31:0] d;
    } iat_row_t;

    logic        hclk        = 1'b0;
    logic        hresetn     = 1'b1;
    logic        hsel        = 1'b0;
    logic [31:0] haddr       = 32'h0;
    logic [1:0]  htrans      = 2'h0;
    logic        hwrite      = 1'b0;
    logic [2:0]  hsize       = 3'h2;
    logic [31:0] hwdata      = 32'h0;
    logic        conv_valid  = 1'b0;
    logic [11:0] conv_result = 12'h0;
    logic [31:0] rd_q;
    logic [31:0] rd;
    wire  logic  hready;
    wire  logic  [31:0] hrdata;
    wire  logic  hreadyout;
    wire  logic  hresp;
    wire  logic  trip_high;
    wire  logic  trip_low;
    wire  logic  overall_alarm_bit;
    wire  logic  irq;
    int          mismatches      = 0;
    int          samples_checked = 0;

    // Host keeps threshold low nibbles zero; reads use d as the expected word
    iat_row_t rows [11] = '{
        '{1'b1, `IAT_OFS_HIGH, 3'h2, 32'hffc5_1230}, '{1'b0, `IAT_OFS_HIGH, 3'h2, 32'hff00_1230},
        '{1'b1, `IAT_OFS_LOW, 3'h2, 32'hffff_0450},  '{1'b0, `IAT_OFS_LOW, 3'h2, 32'h0000_0450},
        '{1'b1, 8'h27, 3'h0, 32'h4000_0000},         '{1'b1, 8'h29, 3'h0, 32'h0000_0300},
        '{1'b1, 8'h24, 3'h1, 32'h0000_0800},         '{1'b0, `IAT_OFS_HIGH, 3'h2, 32'h4000_0800},
        '{1'b0, `IAT_OFS_LOW, 3'h2, 32'h0000_0350},  '{1'b1, `IAT_OFS_IRQ_MASK, 3'h2, 32'h0000_0003},
        '{1'b0, 8'h3c, 3'h2, 32'h0000_0000}
    };

    assign hready = hreadyout;

    iat_regs uut (
        .hclk              (hclk),
        .hresetn           (hresetn),
        .hsel              (hsel),
        .haddr             (haddr),
        .htrans            (htrans),
        .hwrite            (hwrite),
        .hsize             (hsize),
        .hwdata            (hwdata),
        .hready            (hready),
        .hrdata            (hrdata),
        .hreadyout         (hreadyout),
        .hresp             (hresp),
        .conv_valid        (conv_valid),
        .conv_result       (conv_result),
        .trip_high         (trip_high),
        .trip_low          (trip_low),
        .overall_alarm_bit (overall_alarm_bit),
        .irq               (irq)
    );

    always #25 hclk = ~hclk;
    // Read data captured at the edge itself, free of scheduling races
    always @(posedge hclk) rd_q <= hrdata;

    task automatic chk(input string name, input logic [31:0] e, input logic [31:0] g);
        samples_checked++;
        if (g !== e) begin
            mismatches++;
            $display("FAIL %s expected %h seen %h", name, e, g);
        end
    endtask

    task automatic bus(input logic wr, input logic [7:0] a, input logic [2:0] s, input logic [31:0] wd,
                       output logic [31:0] r);
        int n;
        @(posedge hclk);
        hsel <= 1'b1;
        htrans <= `IAT_HTRANS_NONSEQ;
        haddr <= {24'h0, a};
        hwrite <= wr;
        hsize <= s;
        n = 0;
        do begin @(posedge hclk); n++; end while (hready !== 1'b1 && n < 50);
        hsel <= 1'b0;
        htrans <= 2'h0;
        hwdata <= wd;
        n = 0;
        do begin @(posedge hclk); n++; end while (hready !== 1'b1 && n < 50);
        #1 r = rd_q;
        hwdata <= ~wd;
    endtask

    task automatic rdchk(input logic [7:0] a, input logic [31:0] e);
        bus(1'b0, a, 3'h2, 32'h0, rd);
        chk("read", e, rd);
        chk("hresp", 32'h0, {31'h0, hresp});
    endtask

    task automatic irqchk(input logic e);
        @(posedge hclk);
        #1 chk("irq", {31'h0, e}, {31'h0, irq});
    endtask

    task automatic conv(input logic [11:0] r, input logic th, input logic tl);
        @(posedge hclk);
        conv_valid <= 1'b1;
        conv_result <= r;
        @(posedge hclk);
        conv_valid <= 1'b0;
        conv_result <= ~r;
        @(posedge hclk);
        #1 chk("trip_high", {31'h0, th}, {31'h0, trip_high});
        chk("trip_low", {31'h0, tl}, {31'h0, trip_low});
        chk("overall", {31'h0, th | tl}, {31'h0, overall_alarm_bit});
    endtask

    task automatic end_of_test;
        $display("compared %0d mismatched %0d", samples_checked, mismatches);
        if (mismatches == 0 && samples_checked > 0)
            $display("Finished cleanly");
        else
            $display("Finished with errors");
        $finish;
    endtask

    initial begin
        #(50 * 4000);
        mismatches++;
        end_of_test;
    end

    initial begin
        // Scheduled so the design's reset process sees a real falling edge
        hresetn <= 1'b0;
        repeat (20) @(posedge hclk);
        hresetn <= 1'b1;
        foreach (rows[i]) begin
            bus(rows[i].wr, rows[i].a, rows[i].s, rows[i].d, rd);
            if (!rows[i].wr) chk("row read", rows[i].d, rd);
        end
        $display("register table test done");
        // Upper compare 080h with hysteresis 1, lower compare 035h
        conv(12'h080, 1'b0, 1'b0);
        conv(12'h081, 1'b1, 1'b0);
        rdchk(`IAT_OFS_FLAGS, 32'h0000_0011);
        rdchk(`IAT_OFS_IRQ_STAT, 32'h0000_0001);
        irqchk(1'b1);
        conv(12'h080, 1'b1, 1'b0);
        conv(12'h07f, 1'b0, 1'b0);
        irqchk(1'b1);
        bus(1'b1, `IAT_OFS_IRQ_STAT, 3'h2, 32'h0000_0001, rd);
        irqchk(1'b0);
        conv(12'h034, 1'b0, 1'b1);
        rdchk(`IAT_OFS_FLAGS, 32'h0000_0021);
        conv(12'h035, 1'b0, 1'b1);
        conv(12'h036, 1'b0, 1'b0);
        rdchk(`IAT_OFS_SAMPLE, 32'h0000_0036);
        rdchk(`IAT_OFS_IRQ_STAT, 32'h0000_0002);
        bus(1'b1, `IAT_OFS_IRQ_MASK, 3'h2, 32'h0000_0001, rd);
        irqchk(1'b0);
        bus(1'b1, `IAT_OFS_IRQ_STAT, 3'h2, 32'h0000_0002, rd);
        rdchk(`IAT_OFS_IRQ_STAT, 32'h0000_0000);
        $display("alarm and interrupt test done");
        // Mid-run reset with an alarm standing
        conv(12'hfff, 1'b1, 1'b0);
        @(posedge hclk);
        hresetn <= 1'b0;
        repeat (3) @(posedge hclk);
        #1 chk("reset trip", 32'h0, {31'h0, trip_high | overall_alarm_bit | irq});
        hresetn <= 1'b1;
        rdchk(`IAT_OFS_HIGH, 32'h0000_ffff);
        rdchk(`IAT_OFS_LOW, 32'h0000_0000);
        rdchk(`IAT_OFS_IRQ_MASK, 32'h0000_0000);
        bus(1'b1, 8'h26, 3'h1, 32'hc000_0000, rd);
        rdchk(`IAT_OFS_HIGH, 32'hc000_ffff);
        $display("reset test done");
        end_of_test;
    end
endmodule
